// >>> pkg/ebs_pkg.sv
// constants and carrier types shared by the external bus phase sequencer
package ebs_pkg;

	// chip selects
	localparam int NUM_CS = 4;
	localparam int CS_W = 2;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;

	// phase length fields, in chip-select time units
	localparam int AB_BASE_UNITS = 1;
	localparam int ACCESS_BASE_UNITS = 1;
	localparam int RDY_WAIT_UNITS = 1;
	localparam int AB_LEN_W = 3;
	localparam int E_LEN_W = 6;
	localparam int PC_W = 5;
	localparam int UC_W = 2;

	// bus speed limit and the clock this block runs on
	localparam longint CLK_FREQ_HZ = 10_000_000;
	localparam longint MAX_SYS_FREQ_HZ = 80_000_000;
	localparam longint MIN_EDGE_PS = 12500;
	localparam longint CLK_PERIOD_PS = 64'd1_000_000_000_000 / CLK_FREQ_HZ;
	localparam longint MIN_EDGE_CEIL = (MIN_EDGE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int MIN_EDGE_CYC = (CLK_FREQ_HZ <= MAX_SYS_FREQ_HZ || MIN_EDGE_CEIL < 1) ?
		1 : int'(MIN_EDGE_CEIL);
	localparam logic [UC_W-1:0] MIN_UNIT_M1 = UC_W'(MIN_EDGE_CYC - 1);

	// reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

	// per chip-select timing settings
	typedef struct packed {
		logic mux_mode;
		logic ready_en;
		logic ready_pol;
		logic ready_async;
		logic [1:0] cs_time_unit;
		logic addr_setup_len;
		logic [1:0] addr_win_ext;
		logic [1:0] cmd_delay_len;
		logic wdata_setup_len;
		logic [4:0] access_len;
		logic [1:0] hold_len;
	} ebs_cs_cfg_t;

	typedef struct packed {
		logic write;
		logic [CS_W-1:0] cs;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ebs_req_t;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_AB = 7'h02,
		ST_C = 7'h04,
		ST_D = 7'h08,
		ST_E = 7'h10,
		ST_RDY = 7'h20,
		ST_F = 7'h40
	} ebs_state_t;

endpackage : ebs_pkg

// >>> logic/ebs_ready_sync.sv
// ready input conditioning: synchronous path and link-clock-timed asynchronous path
`timescale 1ns/1ns
module ebs_ready_sync (
	// clocks and reset
	input wire logic clk,
	input wire logic link_clk,
	input wire logic resetn,
	// ready pin and its mode
	input wire logic ready_pin,
	input wire logic ready_pol,
	input wire logic ready_async,
	// conditioned level, high means ready
	output logic ready_active
);

	logic link_q;
	logic meta_q;
	logic sync_q;
	logic direct_q;
	logic level;

	// the peripheral drives an asynchronous ready from its own clock
	always_ff @(posedge link_clk or negedge resetn) begin
		if (!resetn) begin
			link_q <= 1'b0;
		end else begin
			link_q <= ready_pin;
		end
	end

	// extra stage costs the async path at least one wait state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			direct_q <= 1'b0;
		end else begin
			meta_q <= link_q; // RL11
			sync_q <= meta_q; // RL11
			direct_q <= ready_pin;
		end
	end

	assign level = ready_async ? sync_q : direct_q;
	assign ready_active = level ~^ ready_pol; // RL10

endmodule : ebs_ready_sync

// >>> logic/ebs_phase_seq.sv
// external bus cycle phase sequencer with ready-stretched access phase
//
// What this block does
// [RL1] Every access runs address setup, command delay, data setup or turnaround, access, hold.
// [RL2] Each phase length comes from the software settings of the selected chip select.
// [RL3] With ready enabled, the external module stretches the access phase and we obey it.
// [RL4] Address setup is 1 or 2 units, plus 0 to 3 units when the chip select window changes.
// [RL5] Command delay 0-3, data setup 0-1, access 1-32, hold 0-3 units.
// [RL6] The third phase is write data setup on writes and bus turnaround in multiplexed mode.
// [RL7] The hold phase keeps address and write data driven after the command ends.
// [RL8] A time unit never falls below the 12.5 ns edge spacing for clocks above 80 MHz up to 320 MHz; above 320 MHz the 2-bit floor wraps.
// [RL9] The bus reference clock output is the system clock itself.
// [RL10] The ready input has a programmable active level.
// [RL11] Asynchronous ready passes a synchroniser and costs at least one wait state.
// [RL12] Ready sampled inactive at the end of access inserts a wait state and samples again.
// [RL13] Read data is captured on the edge that ends the read strobe.
// [RL14] Timing settings are latched at cycle start and held until the hold phase ends.
`timescale 1ns/1ns
module ebs_phase_seq #(
	parameter int NUM_CS = ebs_pkg::NUM_CS
) (
	// clocks and reset
	input wire logic clk,
	input wire logic link_clk,
	input wire logic resetn,
	// timing settings per chip select
	input ebs_pkg::ebs_cs_cfg_t cs_timing_config [NUM_CS],
	// access request
	input wire logic req_valid,
	input ebs_pkg::ebs_req_t req,
	output logic req_ready,
	// completion
	output logic done_valid,
	output logic [ebs_pkg::DATA_W-1:0] rdata,
	// bus pins
	output logic bus_ref_clock_out,
	output logic [ebs_pkg::ADDR_W-1:0] bus_addr,
	output logic [ebs_pkg::DATA_W-1:0] bus_ad_o,
	output logic bus_ad_oe,
	input wire logic [ebs_pkg::DATA_W-1:0] bus_ad_i,
	output logic bus_ale,
	output logic bus_rd_n,
	output logic bus_wr_n,
	output logic [NUM_CS-1:0] bus_cs_n,
	input wire logic bus_ready
);

	ebs_pkg::ebs_state_t state_q, state_d;
	ebs_pkg::ebs_cs_cfg_t cfg_q;
	ebs_pkg::ebs_req_t req_q;
	logic [ebs_pkg::CS_W-1:0] last_cs_q;
	logic last_valid_q;
	logic win_chg_q;
	logic [ebs_pkg::UC_W-1:0] uc_q;
	logic [ebs_pkg::PC_W-1:0] pc_q;
	logic waited_q;
	logic [ebs_pkg::DATA_W-1:0] rdata_q;
	logic done_q;

	// reference clock forwarded unchanged to the fast pad driver
	assign bus_ref_clock_out = clk; // RL9

	logic rdy_act;
	ebs_ready_sync u_rdy (
		.clk(clk),
		.link_clk(link_clk),
		.resetn(resetn),
		.ready_pin(bus_ready),
		.ready_pol(cfg_q.ready_pol),
		.ready_async(cfg_q.ready_async),
		.ready_active(rdy_act)
	);

	// phase lengths in units from the latched settings
	logic [ebs_pkg::AB_LEN_W-1:0] len_ab;
	logic [1:0] len_c;
	logic len_d;
	logic [ebs_pkg::E_LEN_W-1:0] len_e;
	logic [1:0] len_f;
	logic [ebs_pkg::AB_LEN_W-1:0] win_add;

	assign win_add = win_chg_q ? {1'b0, cfg_q.addr_win_ext} : 3'h0; // RL4
	assign len_ab = 3'(ebs_pkg::AB_BASE_UNITS) + {2'h0, cfg_q.addr_setup_len} + win_add; // RL4
	assign len_c = cfg_q.cmd_delay_len; // RL5
	assign len_d = cfg_q.wdata_setup_len; // RL5
	assign len_e = 6'(ebs_pkg::ACCESS_BASE_UNITS) + {1'b0, cfg_q.access_len}; // RL5
	assign len_f = cfg_q.hold_len; // RL5

	// one time unit is cs_time_unit+1 clocks, never shorter than the edge spacing floor
	logic [ebs_pkg::UC_W-1:0] unit_m1;
	assign unit_m1 = (cfg_q.cs_time_unit < ebs_pkg::MIN_UNIT_M1) ?
		ebs_pkg::MIN_UNIT_M1 : cfg_q.cs_time_unit; // RL8

	logic unit_end;
	logic phase_end;
	assign unit_end = (uc_q == 2'h0);
	assign phase_end = unit_end && (pc_q == 5'h00);

	// ready sampling at the last clock of access or of a wait state
	logic need_wait;
	assign need_wait = cfg_q.ready_en &&
		((cfg_q.ready_async && !waited_q) || !rdy_act); // RL3 RL11 RL12

	// zero-length phases are skipped so the order stays AB, C, D, E, F
	ebs_pkg::ebs_state_t after_ab, after_c, after_e;
	assign after_ab = (len_c != 2'h0) ? ebs_pkg::ST_C :
		(len_d ? ebs_pkg::ST_D : ebs_pkg::ST_E); // RL1
	assign after_c = len_d ? ebs_pkg::ST_D : ebs_pkg::ST_E; // RL1
	assign after_e = need_wait ? ebs_pkg::ST_RDY :
		((len_f != 2'h0) ? ebs_pkg::ST_F : ebs_pkg::ST_IDLE); // RL1 RL12

	logic start;
	assign req_ready = (state_q == ebs_pkg::ST_IDLE);
	assign start = req_valid && req_ready;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ebs_pkg::ST_IDLE: begin
				if (start) begin
					state_d = ebs_pkg::ST_AB;
				end
			end
			ebs_pkg::ST_AB: begin
				if (phase_end) begin
					state_d = after_ab;
				end
			end
			ebs_pkg::ST_C: begin
				if (phase_end) begin
					state_d = after_c;
				end
			end
			ebs_pkg::ST_D: begin
				if (phase_end) begin
					state_d = ebs_pkg::ST_E;
				end
			end
			ebs_pkg::ST_E, ebs_pkg::ST_RDY: begin
				if (phase_end) begin
					state_d = after_e; // RL3
				end
			end
			ebs_pkg::ST_F: begin
				if (phase_end) begin
					state_d = ebs_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = ebs_pkg::ST_IDLE;
			end
		endcase
	end

	// units to load on entering the next phase, minus one
	logic [ebs_pkg::PC_W-1:0] load_pc;
	always_comb begin
		case (state_d)
			ebs_pkg::ST_AB: load_pc = 5'(len_ab - 3'h1);
			ebs_pkg::ST_C: load_pc = 5'(len_c - 2'h1);
			ebs_pkg::ST_E: load_pc = 5'(len_e - 6'h01);
			ebs_pkg::ST_F: load_pc = 5'(len_f - 2'h1);
			ebs_pkg::ST_RDY: load_pc = 5'(ebs_pkg::RDY_WAIT_UNITS - 1);
			default: load_pc = 5'h00;
		endcase
	end

	logic entering;
	assign entering = (state_d != state_q) || (phase_end && state_q == ebs_pkg::ST_RDY);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ebs_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// the ab length needs the window flag before the first unit is loaded
	logic [ebs_pkg::PC_W-1:0] start_pc;
	logic start_chg;
	ebs_pkg::ebs_cs_cfg_t sel_cfg;
	assign sel_cfg = cs_timing_config[req.cs];
	assign start_chg = !last_valid_q || (last_cs_q != req.cs); // RL4
	assign start_pc = 5'({2'h0, sel_cfg.addr_setup_len} +
		(start_chg ? {1'b0, sel_cfg.addr_win_ext} : 3'h0));

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			uc_q <= 2'h0;
			pc_q <= 5'h00;
		end else if (start) begin
			uc_q <= (sel_cfg.cs_time_unit < ebs_pkg::MIN_UNIT_M1) ?
				ebs_pkg::MIN_UNIT_M1 : sel_cfg.cs_time_unit; // RL2 RL8
			pc_q <= start_pc; // RL4
		end else if (entering) begin
			uc_q <= unit_m1; // RL2
			pc_q <= load_pc; // RL2
		end else if (unit_end) begin
			uc_q <= unit_m1;
			pc_q <= pc_q - 5'h01;
		end else begin
			uc_q <= uc_q - 2'h1;
		end
	end

	// settings and request are frozen for the whole cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_q <= '0;
			req_q <= '0;
			win_chg_q <= 1'b0;
			last_cs_q <= '0;
			last_valid_q <= 1'b0;
		end else if (start) begin
			cfg_q <= sel_cfg; // RL14
			req_q <= req;
			win_chg_q <= start_chg;
			last_cs_q <= req.cs;
			last_valid_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			waited_q <= 1'b0;
		end else if (start) begin
			waited_q <= 1'b0;
		end else if (state_d == ebs_pkg::ST_RDY) begin
			waited_q <= 1'b1; // RL11
		end
	end

	// phase decode
	logic in_ab, in_c, in_d, in_cmd, in_f, busy, cmd_end;
	assign in_ab = (state_q == ebs_pkg::ST_AB);
	assign in_c = (state_q == ebs_pkg::ST_C);
	assign in_d = (state_q == ebs_pkg::ST_D);
	assign in_cmd = (state_q == ebs_pkg::ST_E) || (state_q == ebs_pkg::ST_RDY);
	assign in_f = (state_q == ebs_pkg::ST_F);
	assign busy = !req_ready;
	assign cmd_end = in_cmd && phase_end && (after_e != ebs_pkg::ST_RDY);

	// read data is taken on the edge that lifts the read strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= ebs_pkg::DATA_RST;
			done_q <= 1'b0;
		end else begin
			if (cmd_end && !req_q.write) begin
				rdata_q <= bus_ad_i; // RL13
			end
			done_q <= busy && (state_d == ebs_pkg::ST_IDLE);
		end
	end

	assign done_valid = done_q;
	assign rdata = rdata_q;

	// pin values for the coming cycle, so address and data leave straight from flops
	// and no decode glitch reaches the pads
	ebs_pkg::ebs_req_t req_next;
	logic mux_next, addr_on_ad_next, wdata_on_ad_next;
	logic [ebs_pkg::ADDR_W-1:0] addr_d, addr_q;
	logic [ebs_pkg::DATA_W-1:0] ad_o_d, ad_o_q;
	assign req_next = start ? req : req_q;
	assign mux_next = start ? sel_cfg.mux_mode : cfg_q.mux_mode;
	assign addr_on_ad_next = mux_next &&
		((state_d == ebs_pkg::ST_AB) || (state_d == ebs_pkg::ST_C)); // RL6
	assign wdata_on_ad_next = req_next.write && ((state_d == ebs_pkg::ST_D) ||
		(state_d == ebs_pkg::ST_E) || (state_d == ebs_pkg::ST_RDY) ||
		(state_d == ebs_pkg::ST_F)); // RL6 RL7
	assign addr_d = (state_d != ebs_pkg::ST_IDLE) ?
		req_next.addr : ebs_pkg::ADDR_RST; // RL7
	assign ad_o_d = addr_on_ad_next ? req_next.addr[ebs_pkg::DATA_W-1:0] :
		(wdata_on_ad_next ? req_next.wdata : ebs_pkg::DATA_RST);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			addr_q <= ebs_pkg::ADDR_RST;
			ad_o_q <= ebs_pkg::DATA_RST;
		end else begin
			addr_q <= addr_d; // RL7
			ad_o_q <= ad_o_d; // RL6
		end
	end

	// address stays on the pins through hold; command only in access and wait
	assign bus_addr = addr_q; // RL7
	assign bus_ale = in_ab;
	assign bus_rd_n = !(in_cmd && !req_q.write);
	assign bus_wr_n = !(in_cmd && req_q.write);

	// multiplexed: address in setup and delay, then turnaround or write data
	logic addr_on_ad, wdata_on_ad;
	assign addr_on_ad = cfg_q.mux_mode && (in_ab || in_c);
	assign wdata_on_ad = req_q.write && (in_d || in_cmd || in_f); // RL6 RL7
	assign bus_ad_oe = addr_on_ad || wdata_on_ad; // RL6
	assign bus_ad_o = ad_o_q; // RL6

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CS; gi++) begin : g_cs
			assign bus_cs_n[gi] = !(busy && (req_q.cs == ebs_pkg::CS_W'(gi)));
		end
	endgenerate

endmodule : ebs_phase_seq

// >>> sim/ebs_seq_monitor.sv
// port assertions for the bus phase sequencer
`timescale 1ns/1ns
module ebs_seq_monitor #(
	parameter int NUM_CS = 4
) (
	// clock and reset
	input logic clk,
	input logic resetn,
	// request side
	input logic req_valid,
	input logic req_ready,
	input logic done_valid,
	// bus pins
	input logic bus_ref_clock_out,
	input logic [ebs_pkg::ADDR_W-1:0] bus_addr,
	input logic [ebs_pkg::DATA_W-1:0] bus_ad_o,
	input logic bus_ad_oe,
	input logic bus_ale,
	input logic bus_rd_n,
	input logic bus_wr_n,
	input logic [NUM_CS-1:0] bus_cs_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	AST_REF_CLK:
	assert property (@(negedge clk) bus_ref_clock_out) else $error("ref clock not high");
	AST_REF_CLK_LOW:
	assert property (!bus_ref_clock_out) else $error("ref clock not low");
	AST_MUX_ADDR:
	assert property (bus_ale && bus_ad_oe |-> bus_ad_o == bus_addr[ebs_pkg::DATA_W-1:0])
		else $error("mux address wrong");
	AST_IDLE_QUIET:
	assert property (req_ready |-> &bus_cs_n && bus_rd_n && bus_wr_n && !bus_ale)
		else $error("bus active while idle");
	AST_ONE_CS:
	assert property (!req_ready |-> $countones(~bus_cs_n) == 1) else $error("chip select");
	AST_ALE_START:
	assert property ($rose(bus_ale) |-> $past(req_valid && req_ready)) else $error("ale");
	AST_CMD_AFTER_SETUP:
	assert property ($fell(bus_rd_n) || $fell(bus_wr_n) |-> !bus_ale && $past(!req_ready))
		else $error("command too early");
	AST_RD_FLOAT:
	assert property (!bus_rd_n |-> !bus_ad_oe) else $error("driving during read");
	AST_WR_DRIVE:
	assert property (!bus_wr_n |-> bus_ad_oe) else $error("write data not driven");
	AST_HOLD_KEEP:
	assert property ($rose(bus_wr_n) && !done_valid |-> bus_ad_oe && $stable(bus_addr))
		else $error("hold lost");
	AST_ADDR_HELD:
	assert property (!req_ready && $past(!req_ready) |-> $stable(bus_addr) && $stable(bus_cs_n))
		else $error("address moved");
	AST_DONE_ONCE:
	assert property (done_valid |=> !done_valid) else $error("done too long");
	AST_DONE_AFTER_BUSY:
	assert property (done_valid |-> $past(!req_ready) && &bus_cs_n) else $error("stray done");
endmodule : ebs_seq_monitor
bind ebs_phase_seq ebs_seq_monitor #(.NUM_CS(NUM_CS)) u_mon (.clk, .resetn, .req_valid,
	.req_ready, .done_valid, .bus_ref_clock_out, .bus_addr, .bus_ad_o, .bus_ad_oe, .bus_ale,
	.bus_rd_n,
	.bus_wr_n, .bus_cs_n);

// >>> sim/ebs_mem_model.sv
// external memory model: stores writes, answers reads, paces ready
`timescale 1ns/1ns
module ebs_mem_model (
	// bus clock and strobes
	input wire logic clk,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [23:0] addr,
	input wire logic [15:0] ad_o,
	// answers
	output logic [15:0] ad_i,
	output logic ready,
	// pacing chosen by the bench
	input wire logic pol,
	input wire logic [7:0] wait_n
);
	logic [15:0] mem [4] = '{default: 16'h0000};
	int cnt = 0;
	always @(posedge clk) begin
		cnt <= (rd_n && wr_n) ? 0 : cnt + 1;
		if (!wr_n) mem[addr[1:0]] <= ad_o;
	end
	// released bus shows the inverse, so a late capture cannot pass
	assign ad_i = rd_n ? ~mem[addr[1:0]] : mem[addr[1:0]];
	assign ready = (cnt >= wait_n) == pol;
endmodule : ebs_mem_model

// >>> sim/tb.sv
// bench: bus accesses checked for cycle length and read data
`timescale 1ns/1ns
module tb;
	logic clk = 0, link_clk = 0, resetn = 0, req_valid = 0, pol = 1;
	logic [7:0] wait_n = 8'h00;
	ebs_pkg::ebs_cs_cfg_t cfg [4];
	ebs_pkg::ebs_req_t req = '0;
	logic req_ready, done_valid, ref_clk, ad_oe, ale, rd_n, wr_n, ready;
	logic [15:0] rdata, ad_o, ad_i;
	logic [15:0] ex [4];
	logic [23:0] addr;
	logic [3:0] cs_n;
	int num_errors = 0, checks_done = 0, cyc = 0;
	always #50 clk = ~clk;
	initial begin
		#7;
		forever #15 link_clk = ~link_clk;
	end
	ebs_phase_seq dut (.clk, .link_clk, .resetn, .cs_timing_config(cfg), .req_valid, .req,
		.req_ready, .done_valid, .rdata, .bus_ref_clock_out(ref_clk), .bus_addr(addr),
		.bus_ad_o(ad_o), .bus_ad_oe(ad_oe), .bus_ad_i(ad_i), .bus_ale(ale),
		.bus_rd_n(rd_n), .bus_wr_n(wr_n), .bus_cs_n(cs_n), .bus_ready(ready));
	ebs_mem_model mem (.clk(ref_clk), .rd_n, .wr_n, .addr, .ad_o, .ad_i, .ready, .pol,
		.wait_n);
	task print_verdict;
		if (num_errors == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			num_errors++;
			print_verdict();
		end
	end
	task chk(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : chk
	// clocks of all phases plus the done cycle, no ready waits
	function automatic int plen(ebs_pkg::ebs_cs_cfg_t c, bit nw);
		int u;
		u = c.cs_time_unit + 1;
		return u * (c.addr_setup_len + 1 + (nw ? c.addr_win_ext : 0) + c.cmd_delay_len
			+ c.wdata_setup_len + c.access_len + 1 + c.hold_len) + 1;
	endfunction : plen
	task acc(input bit w, input logic [1:0] cs, input logic [15:0] d, input bit nw,
		input int lo, input int hi);
		int n, e;
		e = plen(cfg[cs], nw);
		req.write = w;
		req.cs = cs;
		req.addr = 24'(cs);
		req.wdata = d;
		@(negedge clk);
		req_valid = 1;
		@(negedge clk);
		req_valid = 0;
		n = 1;
		while (done_valid !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		chk(n >= e + lo && n <= e + hi, "cycle length");
		if (!w) chk(rdata === ex[cs], "read data");
		else ex[cs] = d;
	endtask : acc
	initial begin
		// fields: mux rdy_en pol async unit setup win_ext cmd dsetup access hold
		cfg[0] = 19'h40881;
		cfg[1] = 19'h0370f;
		cfg[2] = 19'h20104;
		cfg[3] = 19'h39c7e;
		repeat (4) @(negedge clk);
		chk(req_ready === 1'b1 && cs_n === 4'hf && rd_n === 1'b1, "reset state");
		resetn = 1;
		acc(1, 0, 16'ha5a5, 1, 0, 0);
		acc(0, 0, 16'h0000, 0, 0, 0);
		acc(1, 1, 16'h5a3c, 1, 0, 0);
		acc(0, 1, 16'h0000, 0, 0, 0);
		pol = 0;
		acc(1, 2, 16'h0f0f, 1, 0, 0);
		wait_n = 8'h06;
		acc(0, 2, 16'h0000, 0, 1, 8);
		pol = 1;
		wait_n = 8'h00;
		acc(1, 3, 16'hc33c, 1, 1, 4);
		wait_n = 8'h63;
		acc(0, 0, 16'h0000, 1, 0, 0);
		resetn = 0;
		@(negedge clk);
		chk(req_ready === 1'b1 && done_valid === 1'b0 && rdata === 16'h0000, "mid reset");
		resetn = 1;
		acc(0, 0, 16'h0000, 1, 0, 0);
		print_verdict();
	end
endmodule : tb
